// File: hw/tw_ctrl.sv
// two-wire interface controller: flags, bit counter, requests, master transmit
//
// Contract
// - bit_counter clears to zero after each frame with ack, and on start.
// - bit_counter written only when bit_count_write_guard is zero.
// - a flag clears on zero write only after being read as one.
// - master compares SDA with driven bit; mismatch sets arbitration_lost, yields.
// - with ack_check_enable, a one ack halts and sets nack_flag.
// - reading rx_holding_reg clears rx_buffer_full.
// - writing tx_holding_reg clears tx_end and tx_buffer_empty.
// - slave takes SCL as input; master drives SCL itself.
// - four-bit divider code picks peripheral clock divide ratio.
// - five requests from enable and flag pairs.
// - all requests merged onto one interrupt output.
// - sync format masks stop request and nack; lost flag means overrun.
// - tx_buffer_empty sets on load into shift register; a data write or a zero flag write after a read of one clears it.
// - format_select zero is two-wire format, one is clocked serial.
// - first frame after start is eight bits: address and direction.
// - start issued on one write setting bus_busy with start_stop_guard zero.
// - held byte moves to shift register when free; empty flag sets.
// - byte done with empty set: tx_end on ninth edge, ack captured.
// - stop issued on zero write clearing bus_busy with guard zero.
// - master holds SCL low until new data or stop request.
// - after stop flag sets, interface returns to slave receive.
// - lost arbitration clears master_select and transmit_select.
`timescale 1ns/1ns
`default_nettype none
module tw_ctrl
  import tw_pkg::*;
(
  // clock and resets
  input  wire logic       i_core_clk,
  input  wire logic       i_rst_b,
  input  wire logic       i_sync_reset,
  // configuration
  input  wire logic       i_interface_enable,
  input  wire logic       i_format_select,
  input  wire logic       i_bit_order_select,
  input  wire logic [3:0] i_clock_divider_field,
  input  wire logic       i_ack_check_enable,
  input  wire logic       i_tx_empty_int_enable,
  input  wire logic       i_tx_end_int_enable,
  input  wire logic       i_rx_full_int_enable,
  input  wire logic       i_stop_int_enable,
  input  wire logic       i_nack_int_enable,
  // mode writes
  input  wire logic       i_mode_wr,
  input  wire logic       i_master_select_wr,
  input  wire logic       i_transmit_select_wr,
  // bus busy writes
  input  wire logic       i_bus_busy_wr,
  input  wire logic       i_bus_busy_wdata,
  input  wire logic       i_start_stop_guard,
  // bit counter writes
  input  wire logic       i_bc_wr,
  input  wire logic [2:0] i_bc_wdata,
  input  wire logic       i_bit_count_write_guard,
  // flag register access: read strobe, write strobe with data
  input  wire logic       i_flag_rd,
  input  wire logic       i_flag_wr,
  input  wire logic [4:0] i_flag_wdata,
  // data registers
  input  wire logic       i_tx_wr,
  input  wire logic [7:0] i_tx_wdata,
  input  wire logic       i_rx_rd,
  // lines
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  output logic            o_scl_oe,
  output logic            o_sda_oe,
  // status
  output logic            o_master_select,
  output logic            o_transmit_select,
  output logic            o_bus_busy,
  output logic [2:0]      o_bit_counter,
  output logic            o_tx_buffer_empty,
  output logic            o_tx_end,
  output logic            o_rx_buffer_full,
  output logic            o_stop_flag,
  output logic            o_nack_flag,
  output logic            o_arbitration_lost,
  output logic            o_received_ack_bit,
  output logic [7:0]      o_rx_data,
  // merged request
  output logic            o_irq
);
  // flag vector order: 0 tx empty, 1 tx end, 2 rx full, 3 stop, 4 nack, arbitration in
  // separate bit kept alongside nack in flag index 4 write data
  logic             scl_s, sda_s;
  tw_phase_t        phase, next_phase;
  logic [8:0]       div_cnt, next_div_cnt;
  logic [7:0]       shift, next_shift;
  logic [3:0]       bit_idx, next_bit_idx;
  logic             shift_full, next_shift_full;
  logic [7:0]       tx_hold, next_tx_hold;
  logic             master_select, next_mst, transmit_select, next_trs, busy, next_busy;
  logic [2:0]       bc, next_bc;
  logic             tx_buffer_empty, next_tx_buffer_empty, tx_end, next_tx_end, rx_buffer_full, next_rx_buffer_full;
  logic             stp, next_stp, nack_flag, next_nack_flag, al, next_al, received_ack_bit, next_received_ack_bit;
  logic [5:0]       rd_seen, next_rd_seen;
  logic             scl_oe, next_scl_oe, sda_oe, next_sda_oe, irq, next_irq;
  logic             scl_q, next_scl_q, sda_q, next_sda_q;
  logic [8:0]       half;
  logic             tick, drive_bit, start_det, stop_det;

  tw_sync u_sync_scl (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_async(i_scl),
                      .o_sync(scl_s));
  tw_sync u_sync_sda (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_async(i_sda),
                      .o_sync(sda_s));

  // half period from the selected ratio, so a bit spends one half low and one high
  always_comb begin
    half = i_clock_divider_field[3] ? TW_DIV_HI[i_clock_divider_field[2:0]]
                                    : TW_DIV_LO[i_clock_divider_field[2:0]];
    half = {1'b0, half[8:1]};
    tick = (div_cnt >= half - 9'h001);
    drive_bit = i_bit_order_select ? shift[0] : shift[7];
    start_det = scl_s && scl_q && sda_q && !sda_s;
    stop_det  = scl_s && scl_q && !sda_q && sda_s;
  end

  // next-state logic for all control state
  always_comb begin
    next_phase = phase;   next_div_cnt = tick ? 9'h000 : div_cnt + 9'h001;
    next_shift = shift;   next_bit_idx = bit_idx;  next_shift_full = shift_full;
    next_tx_hold = tx_hold; next_mst = master_select; next_trs = transmit_select; next_busy = busy;
    next_bc = bc; next_tx_buffer_empty = tx_buffer_empty; next_tx_end = tx_end; next_rx_buffer_full = rx_buffer_full;
    next_stp = stp; next_nack_flag = nack_flag; next_al = al; next_received_ack_bit = received_ack_bit;
    next_rd_seen = rd_seen; next_scl_oe = scl_oe; next_sda_oe = sda_oe;
    next_scl_q = scl_s; next_sda_q = sda_s;
    // software side: flag clears by zero write need a prior read of one
    if (i_flag_rd)
      next_rd_seen = {al, nack_flag, stp, rx_buffer_full, tx_end, tx_buffer_empty};
    if (i_flag_wr) begin
      if (!i_flag_wdata[0] && rd_seen[0]) next_tx_buffer_empty  = 1'b0;
      if (!i_flag_wdata[1] && rd_seen[1]) next_tx_end  = 1'b0;
      if (!i_flag_wdata[2] && rd_seen[2]) next_rx_buffer_full  = 1'b0;
      if (!i_flag_wdata[3] && rd_seen[3]) next_stp   = 1'b0;
      if (!i_flag_wdata[4] && rd_seen[4]) next_nack_flag = 1'b0;
      if (!i_flag_wdata[4] && rd_seen[5]) next_al    = 1'b0;
      next_rd_seen = 6'h00;
    end
    if (i_rx_rd) next_rx_buffer_full = 1'b0;
    if (i_tx_wr) begin
      next_tx_hold = i_tx_wdata;
      next_tx_buffer_empty = 1'b0;
      next_tx_end = 1'b0;
    end
    if (i_mode_wr) begin
      next_mst = i_master_select_wr;
      next_trs = i_transmit_select_wr;
      if (i_transmit_select_wr && !transmit_select) next_tx_buffer_empty = 1'b1;
    end
    if (i_bc_wr && !i_bit_count_write_guard) next_bc = i_bc_wdata;
    // idle bus: slave side only watches start and stop
    if (start_det) begin
      next_bc = TW_BC_CLEAR;
      next_busy = 1'b1;
    end
    if (stop_det) begin
      next_busy = 1'b0;
      if (!i_format_select) next_stp = 1'b1;
      next_mst = 1'b0;
      next_trs = 1'b0;
    end
    // load the shift register once free; first load after start is the address
    if (!shift_full && !tx_buffer_empty && !i_tx_wr && transmit_select && phase != TW_IDLE) begin
      next_shift = tx_hold;
      next_shift_full = 1'b1;
      next_tx_buffer_empty = 1'b1;
    end
    if (!i_interface_enable || !master_select) begin
      next_phase = TW_IDLE; next_scl_oe = 1'b0; next_sda_oe = 1'b0;
      if (i_bus_busy_wr && !i_start_stop_guard && i_bus_busy_wdata && master_select)
        next_phase = TW_START;
    end else begin
      unique case (phase)
        TW_IDLE: begin
          if (i_bus_busy_wr && !i_start_stop_guard && i_bus_busy_wdata && !busy) begin
            next_phase = TW_START; next_div_cnt = 9'h000;
          end
        end
        TW_START: begin
          next_sda_oe = 1'b1;
          if (tick) begin
            next_scl_oe = 1'b1; next_phase = TW_HOLD; next_bit_idx = 4'h0;
            next_busy = 1'b1; next_bc = TW_BC_CLEAR;
          end
        end
        TW_HOLD: begin
          next_scl_oe = 1'b1;
          next_div_cnt = 9'h000;
          if (i_bus_busy_wr && !i_start_stop_guard && !i_bus_busy_wdata)
            next_phase = TW_STOP_LO;
          else if (shift_full) begin
            next_phase = TW_LOW; next_sda_oe = !drive_bit;
          end
        end
        TW_LOW: begin
          next_scl_oe = 1'b1;
          next_sda_oe = (bit_idx == TW_FRAME_BITS) ? 1'b0 : !drive_bit;
          if (tick) begin next_phase = TW_HIGH; next_scl_oe = 1'b0; end
        end
        TW_HIGH: begin
          // count from release so the period is exact; a stretched low holds the count
          if (!scl_s && div_cnt >= TW_SYNC_LAT) next_div_cnt = TW_SYNC_LAT;
          if (scl_s && bit_idx < TW_FRAME_BITS && !sda_oe && !sda_s
              && !i_format_select) begin
            next_al = 1'b1; next_mst = 1'b0; next_trs = 1'b0;
            next_phase = TW_IDLE; next_sda_oe = 1'b0; next_shift_full = 1'b0;
          end else if (tick && scl_s) begin
            next_scl_oe = 1'b1; next_phase = TW_LOW;
            next_bit_idx = bit_idx + 4'h1;
            next_shift = i_bit_order_select ? {1'b0, shift[7:1]} : {shift[6:0], 1'b0};
            if (bit_idx < TW_FRAME_BITS) next_bc = bc + 3'h1;
            if (bit_idx == TW_FRAME_BITS) begin
              // ninth edge: ack captured, frame complete
              next_received_ack_bit = sda_s;
              next_bc = TW_BC_CLEAR;
              next_shift_full = 1'b0; next_bit_idx = 4'h0;
              next_phase = TW_HOLD; next_sda_oe = 1'b0;
              if (tx_buffer_empty && !i_tx_wr) next_tx_end = 1'b1;
              if (sda_s && i_ack_check_enable && !i_format_select)
                next_nack_flag = 1'b1;
            end
          end
        end
        TW_STOP_LO: begin
          next_scl_oe = 1'b1; next_sda_oe = 1'b1;
          if (tick) begin next_phase = TW_STOP_HI; next_scl_oe = 1'b0; end
        end
        TW_STOP_HI: begin
          if (tick && scl_s) begin
            next_sda_oe = 1'b0; next_phase = TW_IDLE; // stop detector sets stop flag
          end
        end
        default: next_phase = TW_IDLE;
      endcase
    end
    // with ack check on, nack halts further frames until a stop request or nack_flag is cleared
    if (nack_flag && phase == TW_LOW && bit_idx == 4'h0 && i_ack_check_enable)
      next_phase = TW_HOLD;
    // merged request, stop and nack masked in clocked serial format
    next_irq = (i_tx_empty_int_enable && tx_buffer_empty) || (i_tx_end_int_enable && tx_end)
             || (i_rx_full_int_enable && rx_buffer_full)
             || (!i_format_select && i_stop_int_enable && stp)
             || (i_nack_int_enable && (al || (!i_format_select && nack_flag)));
    if (i_sync_reset) begin
      next_phase = TW_IDLE; next_mst = 1'b0; next_trs = 1'b0; next_busy = 1'b0;
      next_bc = TW_BC_CLEAR; next_tx_buffer_empty = 1'b0; next_tx_end = 1'b0; next_rx_buffer_full = 1'b0;
      next_stp = 1'b0; next_nack_flag = 1'b0; next_al = 1'b0; next_received_ack_bit = 1'b0;
      next_rd_seen = 6'h00; next_scl_oe = 1'b0; next_sda_oe = 1'b0;
      next_shift_full = 1'b0; next_irq = 1'b0;
    end
  end

  // registers only
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      phase <= TW_IDLE; div_cnt <= 9'h000; shift <= 8'h00; bit_idx <= 4'h0;
      shift_full <= 1'b0; tx_hold <= 8'h00; master_select <= 1'b0; transmit_select <= 1'b0; busy <= 1'b0;
      bc <= TW_BC_CLEAR; tx_buffer_empty <= 1'b0; tx_end <= 1'b0; rx_buffer_full <= 1'b0; stp <= 1'b0;
      nack_flag <= 1'b0; al <= 1'b0; received_ack_bit <= 1'b0; rd_seen <= 6'h00; scl_oe <= 1'b0;
      sda_oe <= 1'b0; irq <= 1'b0; scl_q <= 1'b1; sda_q <= 1'b1;
    end else begin
      phase <= next_phase; div_cnt <= next_div_cnt; shift <= next_shift;
      bit_idx <= next_bit_idx; shift_full <= next_shift_full; tx_hold <= next_tx_hold;
      master_select <= next_mst; transmit_select <= next_trs; busy <= next_busy; bc <= next_bc;
      tx_buffer_empty <= next_tx_buffer_empty; tx_end <= next_tx_end; rx_buffer_full <= next_rx_buffer_full; stp <= next_stp;
      nack_flag <= next_nack_flag; al <= next_al; received_ack_bit <= next_received_ack_bit; rd_seen <= next_rd_seen;
      scl_oe <= next_scl_oe; sda_oe <= next_sda_oe; irq <= next_irq;
      scl_q <= next_scl_q; sda_q <= next_sda_q;
    end
  end

  // outputs straight from flops
  assign o_scl_oe = scl_oe;            assign o_sda_oe = sda_oe;
  assign o_master_select = master_select;        assign o_transmit_select = transmit_select;
  assign o_bus_busy = busy;            assign o_bit_counter = bc;
  assign o_tx_buffer_empty = tx_buffer_empty;     assign o_tx_end = tx_end;
  assign o_rx_buffer_full = rx_buffer_full;      assign o_stop_flag = stp;
  assign o_nack_flag = nack_flag;          assign o_arbitration_lost = al;
  assign o_received_ack_bit = received_ack_bit;   assign o_rx_data = tx_hold;
  assign o_irq = irq;
endmodule
`default_nettype wire

// File: hw/tw_pkg.sv
// package of constants and types for the two-wire interface controller
package tw_pkg;
  // transfer clock divider ratios, indexed by the four-bit divider code
  localparam logic [8:0] TW_DIV_LO [0:7] = '{9'h01C, 9'h028, 9'h030, 9'h040,
                                             9'h050, 9'h064, 9'h070, 9'h080};
  localparam logic [8:0] TW_DIV_HI [0:7] = '{9'h038, 9'h050, 9'h060, 9'h080,
                                             9'h0A0, 9'h0C8, 9'h0E0, 9'h100};
  localparam logic [2:0] TW_BC_CLEAR   = 3'h0;
  localparam logic [3:0] TW_FRAME_BITS = 4'h8;
  localparam logic [3:0] TW_ACK_SLOT   = 4'h9;
  localparam int         TW_DIV_BITS   = 9;
  // cycles the line synchroniser lags the pin; the high half absorbs them
  localparam logic [8:0] TW_SYNC_LAT   = 9'h002;
  // byte engine phases
  typedef enum logic [2:0] {TW_IDLE, TW_START, TW_LOW, TW_HIGH, TW_HOLD, TW_STOP_LO,
                            TW_STOP_HI} tw_phase_t;
endpackage

// File: hw/tw_sync.sv
// two-flop synchroniser for an open-drain line level
`timescale 1ns/1ns
`default_nettype none
module tw_sync (
  // clock and reset
  input  wire logic i_core_clk,
  input  wire logic i_rst_b,
  // asynchronous line
  input  wire logic i_async,
  // synchronised level
  output logic      o_sync
);
  logic stage1;
  logic next_stage1;
  logic next_sync;

  // first stage feeds only the second; lines idle high
  always_comb begin
    next_stage1 = i_async;
    next_sync   = stage1;
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      stage1 <= 1'b1;
      o_sync <= 1'b1;
    end else begin
      stage1 <= next_stage1;
      o_sync <= next_sync;
    end
  end
endmodule
`default_nettype wire

// File: verification/tw_ctrl_assertions.sv
// concurrent checks on the two-wire controller ports
`timescale 1ns/1ns
`default_nettype none
module tw_ctrl_assertions (
  // clock, resets and configuration
  input wire logic       i_core_clk, i_rst_b, i_sync_reset, i_format_select,
  input wire logic       i_ack_check_enable, i_tx_empty_int_enable, i_tx_end_int_enable,
  input wire logic       i_rx_full_int_enable, i_stop_int_enable, i_nack_int_enable,
  // strobes
  input wire logic       i_bc_wr, i_bit_count_write_guard, i_tx_wr, i_rx_rd,
  input wire logic [2:0] i_bc_wdata,
  // outputs
  input wire logic       o_scl_oe, o_master_select, o_transmit_select, o_bus_busy,
  input wire logic       o_tx_buffer_empty, o_tx_end, o_rx_buffer_full, o_stop_flag,
  input wire logic       o_nack_flag, o_arbitration_lost, o_irq,
  input wire logic [2:0] o_bit_counter
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);
  // merged request; clocked format masks stop and nack sources
  wire logic req = (i_tx_empty_int_enable & o_tx_buffer_empty) | (i_tx_end_int_enable & o_tx_end)
    | (i_rx_full_int_enable & o_rx_buffer_full) | (!i_format_select & i_stop_int_enable & o_stop_flag)
    | (i_nack_int_enable & (o_arbitration_lost | (!i_format_select & o_nack_flag)));
  sequence stop_seen; $rose(o_stop_flag); endsequence
  sequence lost_seen; $rose(o_arbitration_lost); endsequence
  irq_merge_a: assert property (!$past(i_sync_reset) |-> o_irq == $past(req))
    else $error("irq differs from merged request");
  tx_clear_a: assert property (i_tx_wr && !i_sync_reset |=> !o_tx_end)
    else $error("tx_end kept after data write");
  rx_clear_a: assert property (i_rx_rd |=> !o_rx_buffer_full)
    else $error("rx_buffer_full kept after read");
  bc_guard_a: assert property (i_bc_wr && i_bit_count_write_guard && !i_sync_reset
    |=> $stable(o_bit_counter)) else $error("guarded counter write took effect");
  bc_write_a: assert property (i_bc_wr && !i_bit_count_write_guard && !i_sync_reset
    |=> o_bit_counter == $past(i_bc_wdata)) else $error("counter write lost");
  sreset_a: assert property (i_sync_reset |=> !o_bus_busy && !o_master_select && !o_tx_end
    && !o_nack_flag && !o_scl_oe && o_bit_counter == 3'h0) else $error("sync reset incomplete");
  lost_yield_a: assert property (lost_seen |-> ##[0:2] (!o_master_select && !o_transmit_select))
    else $error("bus not yielded after lost arbitration");
  stop_slave_a: assert property (stop_seen |-> ##[0:2] (!o_master_select && !o_bus_busy))
    else $error("no slave mode after stop");
  slave_scl_a: assert property (!o_master_select && !$past(o_master_select, 2) |-> !o_scl_oe)
    else $error("scl driven in slave mode");
  nack_gate_a: assert property ($rose(o_nack_flag) |-> $past(i_ack_check_enable))
    else $error("nack flag without ack check");
endmodule
bind tw_ctrl tw_ctrl_assertions u_tw_ctrl_assertions (.*);
`default_nettype wire

// File: verification/tw_ctrl_tb.sv
// self-checking bench for the two-wire controller
`timescale 1ns/1ns
`default_nettype none
module tw_ctrl_tb;
  logic clk = 1'b0, rst_b = 1'b0, srst = 1'b0, en = 1'b0, ie = 1'b0, ack_en = 1'b0, md = 1'b0;
  logic mode_wr = 1'b0, bb_wr = 1'b0, bb_d = 1'b0, bc_wr = 1'b0, bc_g = 1'b0, f_rd = 1'b0;
  logic f_wr = 1'b0, tx_wr = 1'b0, rx_rd = 1'b0, nack = 1'b0, clash = 1'b0, scl_q = 1'b1;
  logic [3:0] div = 4'h0;
  logic [2:0] bc_d = 3'h0, bc;
  logic [4:0] f_d = 5'h1F;
  logic [7:0] tx_d = 8'h00, s_byte, d8;
  logic scl_oe, sda_oe, m_sda, ms, ts, bb, tx_buffer_empty, tx_end, rx_buffer_full, stp, nf, al, ackb, irq;
  wire logic scl = ~scl_oe;
  wire logic sda = ~(sda_oe | m_sda);
  int n_fail = 0, n_checks = 0, cyc = 0, last = 0, per = 0;
  int ratio [16] = '{28, 40, 48, 64, 80, 100, 112, 128, 56, 80, 96, 128, 160, 200, 224, 256};
  always #2 clk = ~clk;
  tw_ctrl u_tw_ctrl (.i_core_clk(clk), .i_rst_b(rst_b), .i_sync_reset(srst),
    .i_interface_enable(en), .i_format_select(1'b0), .i_bit_order_select(1'b0),
    .i_clock_divider_field(div), .i_ack_check_enable(ack_en), .i_tx_empty_int_enable(ie),
    .i_tx_end_int_enable(ie), .i_rx_full_int_enable(1'b0), .i_stop_int_enable(1'b0),
    .i_nack_int_enable(ie), .i_mode_wr(mode_wr), .i_master_select_wr(md),
    .i_transmit_select_wr(md), .i_bus_busy_wr(bb_wr), .i_bus_busy_wdata(bb_d),
    .i_start_stop_guard(1'b0), .i_bc_wr(bc_wr), .i_bc_wdata(bc_d),
    .i_bit_count_write_guard(bc_g), .i_flag_rd(f_rd), .i_flag_wr(f_wr), .i_flag_wdata(f_d),
    .i_tx_wr(tx_wr), .i_tx_wdata(tx_d), .i_rx_rd(rx_rd), .i_scl(scl), .i_sda(sda),
    .o_scl_oe(scl_oe), .o_sda_oe(sda_oe), .o_master_select(ms), .o_transmit_select(ts),
    .o_bus_busy(bb), .o_bit_counter(bc), .o_tx_buffer_empty(tx_buffer_empty), .o_tx_end(tx_end),
    .o_rx_buffer_full(rx_buffer_full), .o_stop_flag(stp), .o_nack_flag(nf), .o_arbitration_lost(al),
    .o_received_ack_bit(ackb), .o_rx_data(), .o_irq(irq));
  tw_slave_model u_tw_slave_model (.i_scl(scl), .i_sda(sda), .i_nack(nack), .i_clash(clash),
    .o_sda_oe(m_sda), .o_byte(s_byte));
  // scl period between rising edges; hang guard
  always @(posedge clk) begin
    cyc++;
    scl_q <= scl;
    if (scl && !scl_q) begin
      per = cyc - last;
      last = cyc;
    end
    if (cyc == 60000) begin
      n_fail++;
      summarize();
    end
  end
  task automatic chk_bit(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  function automatic logic ev(input int w);
    case (w)
      0: return tx_buffer_empty;
      1: return tx_end | nf;
      2: return stp;
      default: return al;
    endcase
  endfunction
  // bounded wait; a miss shows up in the following compares
  task automatic wait_ev(input int w);
    for (int i = 0; i < 5000 && ev(w) !== 1'b1; i++) tick(1);
  endtask
  task automatic clr_flags(input logic [4:0] v);
    f_rd = 1'b1;
    tick(1);
    f_rd = 1'b0;
    f_d = v;
    f_wr = 1'b1;
    tick(1);
    f_wr = 1'b0;
    tick(1);
  endtask
  task automatic begin_tx(input logic [3:0] c);
    div = c;
    mode_wr = 1'b1;
    tick(1);
    mode_wr = 1'b0;
    bb_d = 1'b1;
    bb_wr = 1'b1;
    tick(1);
    bb_wr = 1'b0;
    wait_ev(0);
    chk_val(bc, 3'h0);
  endtask
  task automatic send(input logic [7:0] d);
    tx_d = d;
    tx_wr = 1'b1;
    tick(1);
    tx_wr = 1'b0;
    chk_bit(tx_end, 1'b0);
    wait_ev(1);
  endtask
  task automatic stop_tx;
    bb_d = 1'b0;
    bb_wr = 1'b1;
    tick(1);
    bb_wr = 1'b0;
    wait_ev(2);
    tick(3);
    chk_bit(ms, 1'b0);
    clr_flags(5'h01);
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk);
    #1;
    rst_b = 1'b1;
    tick(1);
    chk_bit(ms, 1'b0);
    chk_bit(scl_oe, 1'b0);
    en = 1'b1;
    ie = 1'b1;
    md = 1'b1;
    // one byte per divider code
    for (int i = 0; i < 16; i++) begin
      d8 = {i[3:0], ~i[3:0]};
      begin_tx(i[3:0]);
      send(d8);
      chk_val(per, ratio[i]);
      chk_val(s_byte, d8);
      chk_bit(ackb, 1'b0);
      chk_bit(tx_buffer_empty, 1'b1);
      chk_bit(irq, 1'b1);
      chk_val(bc, 3'h0);
      stop_tx();
      $display("divider code %0d done", i);
    end
    // counter writes in hold, then refused flag clear on nack
    begin_tx(4'h0);
    send(8'h5A);
    bc_g = 1'b1;
    bc_d = 3'h5;
    bc_wr = 1'b1;
    tick(1);
    bc_wr = 1'b0;
    chk_val(bc, 3'h0);
    bc_g = 1'b0;
    bc_wr = 1'b1;
    tick(1);
    bc_wr = 1'b0;
    chk_val(bc, 3'h5);
    send(8'h3C);
    chk_val(s_byte, 8'h3C);
    stop_tx();
    ack_en = 1'b1;
    nack = 1'b1;
    begin_tx(4'h0);
    send(8'hC3);
    chk_bit(nf, 1'b1);
    chk_bit(ackb, 1'b1);
    f_d = 5'h01;
    f_wr = 1'b1;
    tick(1);
    f_wr = 1'b0;
    tick(1);
    chk_bit(nf, 1'b1);
    stop_tx();
    chk_bit(nf, 1'b0);
    nack = 1'b0;
    ack_en = 1'b0;
    $display("counter and nack test done");
    // competing master wins the first bit
    begin_tx(4'h0);
    clash = 1'b1;
    tx_d = 8'hFF;
    tx_wr = 1'b1;
    tick(1);
    tx_wr = 1'b0;
    wait_ev(3);
    tick(3);
    chk_bit(al, 1'b1);
    chk_bit(ts, 1'b0);
    clash = 1'b0;
    tick(20);
    chk_bit(scl_oe, 1'b0);
    clr_flags(5'h01);
    chk_bit(al, 1'b0);
    $display("arbitration test done");
    // sync reset right after the start request, before any byte, then receive read
    begin_tx(4'h0);
    srst = 1'b1;
    tick(1);
    srst = 1'b0;
    chk_bit(bb, 1'b0);
    chk_bit(sda_oe, 1'b0);
    rx_rd = 1'b1;
    tick(1);
    rx_rd = 1'b0;
    chk_bit(rx_buffer_full, 1'b0);
    $display("sync reset test done");
    summarize();
  end
endmodule
`default_nettype wire

// File: verification/tw_slave_model.sv
// behavioural two-wire slave: counts bits, captures byte, answers ack
`timescale 1ns/1ns
`default_nettype none
module tw_slave_model (
  // bus lines and commands
  input  wire logic  i_scl,
  input  wire logic  i_sda,
  input  wire logic  i_nack,
  input  wire logic  i_clash,
  // sda pull-down and captured byte
  output logic       o_sda_oe,
  output logic [7:0] o_byte
);
  int   nbit = 0;
  logic ack_on = 1'b0;
  initial o_byte = 8'h00;
  // start condition restarts the frame count
  always @(negedge i_sda) if (i_scl === 1'b1) nbit = 0;
  // bits taken on scl rise, eight of them per frame
  always @(posedge i_scl) begin
    if (nbit < 8) o_byte = {o_byte[6:0], i_sda};
    nbit++;
  end
  // ack held from eighth fall to ninth fall, then released
  always @(negedge i_scl) begin
    ack_on = (nbit == 8) && !i_nack;
    if (nbit >= 9) nbit = 0;
  end
  // a competing master holds sda low while commanded
  assign o_sda_oe = ack_on | i_clash;
endmodule
`default_nettype wire
